// >>> test_wdn_watchdog.sv
`timescale 1ns/10ps
module test_wdn_watchdog;
	import wdn_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, xtal = 1'b0, io_wr = 1'b0, io_rd = 1'b0, sp_paired = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic [3:0] io_wdata = 4'h0;
	logic [3:0] io_rdata;
	logic nmi_req, nmi_ack, halt_wake;
	logic [15:0] vec_addr;
	int miscompares = 0, total_checks = 0, cycles = 0, n;
	// short divider and counter keep the run brief
	wdn_watchdog #(.CNT_W(3), .PRE_DIV(2)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.low_freq_crystal_clock(xtal), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .nmi_req(nmi_req), .nmi_ack(nmi_ack),
		.halt_wake(halt_wake));
	wdn_core_model i_core (.ref_clk(ref_clk), .rst_n(rst_n), .nmi_req(nmi_req),
		.nmi_ack(nmi_ack), .sp_paired(sp_paired), .vec_addr(vec_addr));
	initial forever #4 ref_clk = ~ref_clk;
	// crystal as slow square wave, two cycles per level
	always
	begin
		repeat (2) @(negedge ref_clk);
		xtal = ~xtal;
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		@(negedge ref_clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge ref_clk);
		io_wr = 1'b0;
	endtask : wr
	// read data is registered, so it is looked at one cycle later
	task automatic rd(input logic [15:0] a, input logic [3:0] exp);
		@(negedge ref_clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge ref_clk);
		io_rd = 1'b0;
		chk(io_rdata, exp);
	endtask : rd
	initial
	begin
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		rd(WDN_CTRL_ADDR, 4'h2);
		rd(16'hff06, 4'h0);
		wr(WDN_CTRL_ADDR, 4'h0);
		rd(WDN_CTRL_ADDR, 4'h0);
		repeat (100) @(negedge ref_clk);
		chk(nmi_req, 1'b0);
		$display("test disable done");
		// upper bits and restart strobe must not read back
		wr(WDN_CTRL_ADDR, 4'hf);
		rd(WDN_CTRL_ADDR, 4'h2);
		for (n = 0; n < 5; n++)
		begin
			repeat (40) @(negedge ref_clk);
			chk(nmi_req, 1'b0);
			wr(WDN_CTRL_ADDR, 4'h3);
		end
		$display("test restart done");
		wr(WDN_CTRL_ADDR, 4'h2);
		repeat (48) @(negedge ref_clk);
		chk(nmi_req, 1'b0);
		n = 0;
		while (nmi_req !== 1'b1 && n < 30)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(nmi_req, 1'b1);
		chk(halt_wake, 1'b1);
		repeat (5) @(negedge ref_clk);
		chk(nmi_req, 1'b1);
		sp_paired = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(nmi_req, 1'b0);
		chk(vec_addr, 16'h0100);
		$display("test timeout done");
		// a pending request is dropped by writing the enable bit to 0
		sp_paired = 1'b0;
		n = 0;
		while (nmi_req !== 1'b1 && n < 80)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(nmi_req, 1'b1);
		wr(WDN_CTRL_ADDR, 4'h0);
		chk(nmi_req, 1'b0);
		chk(halt_wake, 1'b0);
		$display("test clear done");
		// mid-run reset with the watchdog stopped part way through a period
		wr(WDN_CTRL_ADDR, 4'h2);
		repeat (40) @(negedge ref_clk);
		wr(WDN_CTRL_ADDR, 4'h0);
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		rd(WDN_CTRL_ADDR, 4'h2);
		// a counter left at its old value would overflow well before this
		repeat (56) @(negedge ref_clk);
		chk(nmi_req, 1'b0);
		n = 0;
		while (nmi_req !== 1'b1 && n < 16)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(nmi_req, 1'b1);
		$display("test reset done");
		end_sim();
	end
endmodule : test_wdn_watchdog

// >>> wdn_core_model.sv
`timescale 1ns/10ps
module wdn_core_model
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// watchdog request and acceptance
	input wire logic nmi_req,
	output logic nmi_ack,
	// stack pointer pair written, vector taken
	input wire logic sp_paired,
	output logic [15:0] vec_addr
);
	logic ack_reg;
	logic ack_next;
	always_comb
	begin
		ack_next = nmi_req && sp_paired && !ack_reg;
	end
	// one-cycle acceptance pulse
	always_ff @(posedge ref_clk)
	begin
		ack_reg <= rst_n ? ack_next : 1'b0;
	end
	assign nmi_ack = ack_reg;
	assign vec_addr = 16'h0100;
endmodule : wdn_core_model

// >>> wdn_pkg.sv
package wdn_pkg;
	// i/o bus geometry
	localparam int WDN_ADDR_W = 16;
	localparam int WDN_DATA_W = 4;
	// control register location and field layout
	localparam logic [15:0] WDN_CTRL_ADDR = 16'hff07;
	localparam int WDN_RESTART_POS = 0;
	localparam int WDN_ENABLE_POS = 1;
	localparam logic WDN_ENABLE_RST = 1'b1;
	// clock tree figures
	localparam int WDN_XTAL_HZ = 32768;
	localparam int WDN_TAP_HZ = 256;
	localparam int WDN_PRE_DIV = WDN_XTAL_HZ / WDN_TAP_HZ;
	// watchdog counter width, final stage at 0.25 hz
	localparam int WDN_CNT_W = 10;
endpackage : wdn_pkg

// >>> wdn_tap_div.sv
`timescale 1ns/10ps
module wdn_tap_div
	import wdn_pkg::*;
#(
	parameter int DIV = WDN_PRE_DIV
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// crystal level, synchronous to ref_clk
	input wire logic xtal_level,
	// one-cycle pulse at the tap rate
	output logic tap_tick
);
	localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

	// a divider below two has no period to count
	if (DIV < 2)
	begin : g_bad_div
		$error("wdn_tap_div: DIV must be at least 2");
	end

	logic xtal_prev_reg, xtal_prev_next;
	logic [DW-1:0] div_reg, div_next;
	logic tick_reg, tick_next;
	logic xtal_rise;

	// divider counts crystal rising edges; free running so restarts land mid-period
	always_comb
	begin
		xtal_rise = xtal_level & ~xtal_prev_reg;
		xtal_prev_next = xtal_level;
		div_next = div_reg;
		tick_next = 1'b0;
		if (xtal_rise)
		begin
			if (div_reg == DW'(DIV - 1))
			begin
				div_next = '0;
				tick_next = 1'b1;
			end
			else
			begin
				div_next = div_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			xtal_prev_reg <= 1'b1; // a crystal already high at release is no edge
			div_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			xtal_prev_reg <= xtal_prev_next;
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tap_tick = tick_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	tick_single_a: assert property (tap_tick |=> !tap_tick)
		else $error("tap tick lasted more than one cycle");
	tick_cause_a: assert property ($rose(tap_tick) |-> $past(div_reg) == DW'(DIV - 1))
		else $error("tap tick without full divider period");
endmodule : wdn_tap_div

// >>> wdn_watchdog.sv
// Functional notes
// - The counter advances on a 256 Hz tap divided from the low-frequency crystal clock.
// - The watchdog is a 10-bit binary counter whose final-stage overflow raises the interrupt.
// - Without a restart for about four seconds while enabled, an interrupt request goes to the core.
// - Counting starts by itself after reset and software may stop it later.
// - Counting continues in halt and the overflow interrupt ends the halt.
// - The enable bit is bit 1 of the watchdog control register, written and read back.
// - With the enable bit at 0 the counter stands and no interrupt is raised.
// - Reset sets the enable bit to 1.
// - Writing 1 to bit 0 clears the counter and counting resumes at once; writing 0 does nothing.
// - Bit 0 and the two upper bits always read as 0.
`timescale 1ns/10ps
module wdn_watchdog
	import wdn_pkg::*;
#(
	parameter int CNT_W = WDN_CNT_W,
	parameter int PRE_DIV = WDN_PRE_DIV
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// crystal clock level, sampled as a plain input
	input wire logic low_freq_crystal_clock,
	// cpu i/o memory port
	input wire logic [WDN_ADDR_W-1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [WDN_DATA_W-1:0] io_wdata,
	output logic [WDN_DATA_W-1:0] io_rdata,
	// non-maskable request toward the core
	output logic nmi_req,
	input wire logic nmi_ack,
	output logic halt_wake
);
	// a counter below two bits has no separate final stage
	if (CNT_W < 2)
	begin : g_bad_cnt_w
		$error("wdn_watchdog: CNT_W must be at least 2");
	end

	logic tap_tick;
	logic ctrl_hit, ctrl_wr, restart_wr, overflow;
	logic enable_reg, enable_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic nmi_reg, nmi_next;
	logic [WDN_DATA_W-1:0] rdata_reg, rdata_next;

	wdn_tap_div #(
		.DIV(PRE_DIV)
	) u_tap (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.xtal_level(low_freq_crystal_clock),
		.tap_tick(tap_tick)
	);

	// register decode
	assign ctrl_hit = (io_addr == WDN_CTRL_ADDR);
	assign ctrl_wr = io_wr & ctrl_hit;
	assign restart_wr = ctrl_wr & io_wdata[WDN_RESTART_POS];
	// overflow of the final stage; a restart in the same cycle wins
	assign overflow = enable_reg & tap_tick & (&cnt_reg) & ~restart_wr;

	// control, counter, request and read data next values
	always_comb
	begin
		enable_next = enable_reg;
		cnt_next = cnt_reg;
		nmi_next = nmi_reg;
		rdata_next = '0;
		if (ctrl_wr)
		begin
			enable_next = io_wdata[WDN_ENABLE_POS];
		end
		// restart clears; stands while disabled; halt does not stop it
		if (restart_wr)
		begin
			cnt_next = '0;
		end
		else if (enable_reg && tap_tick)
		begin
			cnt_next = cnt_reg + 1'b1;
		end
		// request held until the core takes it or enable is written to 0; an overflow beats both
		if (nmi_ack)
		begin
			nmi_next = 1'b0;
		end
		if (ctrl_wr && !io_wdata[WDN_ENABLE_POS])
		begin
			nmi_next = 1'b0;
		end
		if (overflow)
		begin
			nmi_next = 1'b1;
		end
		// restart and upper bits read zero
		if (io_rd && ctrl_hit)
		begin
			rdata_next[WDN_ENABLE_POS] = enable_reg;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			enable_reg <= WDN_ENABLE_RST;
			cnt_reg <= '0;
			nmi_reg <= 1'b0;
			rdata_reg <= '0;
		end
		else
		begin
			enable_reg <= enable_next;
			cnt_reg <= cnt_next;
			nmi_reg <= nmi_next;
			rdata_reg <= rdata_next;
		end
	end

	// the pending request also releases halt
	assign nmi_req = nmi_reg;
	assign halt_wake = nmi_reg;
	assign io_rdata = rdata_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_restart;
		restart_wr;
	endsequence
	sequence s_last_step;
		enable_reg && tap_tick && (&cnt_reg) && !restart_wr;
	endsequence

	restart_clears_a: assert property (s_restart |=> cnt_reg == '0)
		else $error("restart did not clear the counter");
	disabled_hold_a: assert property (!enable_reg && !restart_wr |=> $stable(cnt_reg))
		else $error("counter moved while disabled");
	tick_advance_a: assert property (enable_reg && tap_tick && !restart_wr |=> cnt_reg == $past(cnt_reg) + 1'b1)
		else $error("counter did not advance on tap");
	no_tick_hold_a: assert property (!tap_tick && !restart_wr |=> $stable(cnt_reg))
		else $error("counter moved without a tap");
	overflow_nmi_a: assert property (s_last_step |=> nmi_req && halt_wake && cnt_reg == '0)
		else $error("overflow did not raise the request");
	nmi_cause_a: assert property ($rose(nmi_req) |-> $past(enable_reg) && $past(tap_tick))
		else $error("request rose without an enabled overflow");
	enable_write_a: assert property (ctrl_wr |=> enable_reg == $past(io_wdata[WDN_ENABLE_POS]))
		else $error("enable bit did not take the written value");
	read_back_a: assert property (io_rd && ctrl_hit |=> io_rdata == {2'b00, $past(enable_reg), 1'b0})
		else $error("control read returned wrong bits");
	nmi_hold_a: assert property (nmi_req && !nmi_ack && !ctrl_wr |=> nmi_req)
		else $error("request dropped before acknowledge");
	reset_state_a: assert property (disable iff (1'b0) !rst_n |=> enable_reg && cnt_reg == '0 && !nmi_req)
		else $error("wrong state after reset");
endmodule : wdn_watchdog
